// file: inc/hsc_consts.vh
// constants for the humidity sensor i2c command unit
// assumes a 100 MHz system clock and an external i2c controller
`ifndef HSC_CONSTS_VH
`define HSC_CONSTS_VH

// bus addressing
`define HSC_GCALL_ADDR   7'h00
`define HSC_GCALL_RESET  8'h06

// command bytes
`define HSC_CMD_MEAS_HI  8'hfd
`define HSC_CMD_MEAS_MD  8'hf6
`define HSC_CMD_MEAS_LO  8'he0
`define HSC_CMD_SERIAL   8'h89
`define HSC_CMD_SRESET   8'h94
`define HSC_CMD_HT_HI_L  8'h39
`define HSC_CMD_HT_MD_L  8'h2f
`define HSC_CMD_HT_LO_L  8'h1e
`define HSC_CMD_HT_HI_S  8'h32
`define HSC_CMD_HT_MD_S  8'h24
`define HSC_CMD_HT_LO_S  8'h15

// crc-8 properties
`define HSC_CRC_POLY     8'h31
`define HSC_CRC_INIT     8'hff
`define HSC_CRC_XOROUT   8'h00

// heater power level codes
`define HSC_PWR_OFF      2'h0
`define HSC_PWR_LOW      2'h1
`define HSC_PWR_MID      2'h2
`define HSC_PWR_HIGH     2'h3

// times in their own units and the clock rate
`define HSC_CLK_HZ       100000000
`define HSC_T_LONG_MS    1000
`define HSC_T_SHORT_MS   100
`define HSC_T_MEAS_HI_US 8300
`define HSC_T_MEAS_MD_US 4500
`define HSC_T_MEAS_LO_US 1600
`define HSC_T_SRST_US    100

// derived cycle counts
`define HSC_CYC_LONG     (`HSC_T_LONG_MS * (`HSC_CLK_HZ / 1000))
`define HSC_CYC_SHORT    (`HSC_T_SHORT_MS * (`HSC_CLK_HZ / 1000))
`define HSC_CYC_MEAS_HI  (`HSC_T_MEAS_HI_US * (`HSC_CLK_HZ / 1000000))
`define HSC_CYC_MEAS_MD  (`HSC_T_MEAS_MD_US * (`HSC_CLK_HZ / 1000000))
`define HSC_CYC_MEAS_LO  (`HSC_T_MEAS_LO_US * (`HSC_CLK_HZ / 1000000))
`define HSC_CYC_SRST     (`HSC_T_SRST_US * (`HSC_CLK_HZ / 1000000))

`endif

// file: rtl/hsc_top.v
// i2c target command unit: decode, timed sequences, crc-protected readout
// assumes scl/sda come from pins, an external controller drives scl,
// and TEMP_SAMPLE/HUM_SAMPLE are steady when a measurement ends
`timescale 1ns/1ps
`include "hsc_consts.vh"

module hsc_top #(
    parameter [6:0]  DEV_ADDR   = 7'h44,
    parameter [31:0] SERIAL_NUM = 32'h1234_5678,       // arbitrary value
    parameter [27:0] CYC_LONG   = `HSC_CYC_LONG,
    parameter [27:0] CYC_SHORT  = `HSC_CYC_SHORT,
    parameter [27:0] CYC_M_HI   = `HSC_CYC_MEAS_HI,
    parameter [27:0] CYC_M_MD   = `HSC_CYC_MEAS_MD,
    parameter [27:0] CYC_M_LO   = `HSC_CYC_MEAS_LO,
    parameter [27:0] CYC_SRST   = `HSC_CYC_SRST
) (
    // clock and reset
    input  wire        CLK,
    input  wire        RST_N,
    // i2c pins
    input  wire        SCL_IN,
    input  wire        SDA_IN,
    output wire        SDA_OUT,
    output wire        SDA_OE,
    // sensor front end
    input  wire [15:0] TEMP_SAMPLE,
    input  wire [15:0] HUM_SAMPLE,
    // status
    output reg  [1:0]  HEATER_PWR,
    output reg         BUSY
);

    // state codes of the sequencer, one-hot
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_HEAT = 5'h02;
    localparam [4:0] S_MEAS = 5'h04;
    localparam [4:0] S_SRST = 5'h08;
    localparam [4:0] S_RDY  = 5'h10;

    // bus states, one-hot
    localparam [5:0] B_IDLE = 6'h01;
    localparam [5:0] B_ADDR = 6'h02;
    localparam [5:0] B_AACK = 6'h04;
    localparam [5:0] B_WR   = 6'h08;
    localparam [5:0] B_RD   = 6'h10;
    localparam [5:0] B_MACK = 6'h20;

    // pin synchronisers, two flops each
    reg [1:0] scl_sync_reg;
    reg [1:0] sda_sync_reg;
    reg       scl_d_reg;
    reg       sda_d_reg;
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_d_reg    <= 1'b1;
            sda_d_reg    <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], SCL_IN};
            sda_sync_reg <= {sda_sync_reg[0], SDA_IN};
            scl_d_reg    <= scl_sync_reg[1];
            sda_d_reg    <= sda_sync_reg[1];
        end
    end

    // edge and condition detection on synchronised lines
    wire scl_s   = scl_sync_reg[1];
    wire sda_s   = sda_sync_reg[1];
    wire scl_ris = scl_s & ~scl_d_reg;
    wire scl_fal = ~scl_s & scl_d_reg;
    wire start_c = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire stop_c  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // crc-8 over a 16-bit word
    function [7:0] hsc_crc16;
        input [15:0] w;
        integer i;
        reg [7:0] c;
        begin
            c = `HSC_CRC_INIT;
            for (i = 15; i >= 0; i = i - 1) begin
                if (c[7] ^ w[i])
                    c = {c[6:0], 1'b0} ^ `HSC_CRC_POLY;
                else
                    c = {c[6:0], 1'b0};
            end
            hsc_crc16 = c ^ `HSC_CRC_XOROUT;
        end
    endfunction

    // bus engine registers
    reg [5:0]  bst_reg;
    reg [2:0]  bit_reg;
    reg [7:0]  sh_reg;
    reg        rd_dir_reg;
    reg        gcall_reg;
    reg        ack_reg;
    reg        first_wr_reg;
    reg [2:0]  byte_idx_reg;
    reg        sda_drv_reg;
    reg        skip_fal_reg;
    reg [47:0] res_reg;
    reg        res_valid_reg;
    // sequencer registers
    reg [4:0]  seq_reg;
    reg [27:0] cnt_reg;
    reg [27:0] meas_len_reg;
    reg        serial_reg;

    // command decode of the received byte
    reg        cmd_known;
    reg        cmd_heat;
    reg        cmd_long;
    reg [1:0]  cmd_pwr;
    reg [27:0] cmd_mlen;
    always @* begin
        cmd_known = 1'b1;
        cmd_heat  = 1'b0;
        cmd_long  = 1'b0;
        cmd_pwr   = `HSC_PWR_OFF;
        cmd_mlen  = CYC_M_HI;
        case (sh_reg)
            `HSC_CMD_MEAS_HI: cmd_mlen = CYC_M_HI;
            `HSC_CMD_MEAS_MD: cmd_mlen = CYC_M_MD;
            `HSC_CMD_MEAS_LO: cmd_mlen = CYC_M_LO;
            `HSC_CMD_SERIAL:  cmd_mlen = CYC_M_LO;
            `HSC_CMD_HT_HI_L: begin
                cmd_heat = 1'b1; cmd_long = 1'b1; cmd_pwr = `HSC_PWR_HIGH;
            end
            `HSC_CMD_HT_MD_L: begin
                cmd_heat = 1'b1; cmd_long = 1'b1; cmd_pwr = `HSC_PWR_MID;
            end
            `HSC_CMD_HT_LO_L: begin
                cmd_heat = 1'b1; cmd_long = 1'b1; cmd_pwr = `HSC_PWR_LOW;
            end
            `HSC_CMD_HT_HI_S: begin
                cmd_heat = 1'b1; cmd_pwr = `HSC_PWR_HIGH;
            end
            `HSC_CMD_HT_MD_S: begin
                cmd_heat = 1'b1; cmd_pwr = `HSC_PWR_MID;
            end
            `HSC_CMD_HT_LO_S: begin
                cmd_heat = 1'b1; cmd_pwr = `HSC_PWR_LOW;
            end
            default: cmd_known = 1'b0;
        endcase
    end

    // events from the bus engine to the sequencer
    wire byte_done = (bst_reg == B_WR) & scl_fal & (bit_reg == 3'h0) & ~ack_reg;
    wire cmd_byte  = byte_done & first_wr_reg & ~gcall_reg;
    wire srst_cmd  = (cmd_byte & (sh_reg == `HSC_CMD_SRESET)) |
                     (byte_done & gcall_reg & (sh_reg == `HSC_GCALL_RESET));
    wire busy_now  = (seq_reg != S_IDLE) & (seq_reg != S_RDY);
    wire addr_hit  = (sh_reg[7:1] == DEV_ADDR) |
                     ((sh_reg[7:1] == `HSC_GCALL_ADDR) & ~sh_reg[0]);
    // read header acked only with a result ready
    wire addr_ack  = addr_hit & (~sh_reg[0] | res_valid_reg);
    wire rd_take   = (bst_reg == B_ADDR) & scl_fal & (bit_reg == 3'h0) & ~ack_reg &
                     addr_ack & sh_reg[0];

    // bus engine: sda only, scl is never driven
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            bst_reg      <= B_IDLE;
            bit_reg      <= 3'h7;
            sh_reg       <= 8'h00;
            rd_dir_reg   <= 1'b0;
            gcall_reg    <= 1'b0;
            ack_reg      <= 1'b0;
            first_wr_reg <= 1'b0;
            byte_idx_reg <= 3'h0;
            sda_drv_reg  <= 1'b0;
            skip_fal_reg <= 1'b0;
        end else if (start_c) begin
            bst_reg     <= B_ADDR;
            bit_reg     <= 3'h7;
            ack_reg     <= 1'b0;
            sda_drv_reg <= 1'b0;
            skip_fal_reg <= 1'b1;                      // scl still falls once before bit 7
        end else if (stop_c) begin
            bst_reg     <= B_IDLE;
            sda_drv_reg <= 1'b0;
        end else begin
            case (bst_reg)
                B_IDLE: sda_drv_reg <= 1'b0;
                B_ADDR, B_WR: begin
                    if (scl_ris & ~ack_reg)
                        sh_reg <= {sh_reg[6:0], sda_s};
                    if (scl_fal & skip_fal_reg)
                        skip_fal_reg <= 1'b0;          // fall closing the start, no bit
                    else if (scl_fal & ack_reg) begin
                        ack_reg     <= 1'b0;
                        sda_drv_reg <= 1'b0;
                        bit_reg     <= 3'h7;
                        if (bst_reg == B_ADDR) begin
                            bst_reg <= rd_dir_reg ? B_RD : B_WR;
                            if (rd_dir_reg)            // first data bit out
                                sda_drv_reg <= ~res_reg[47];
                        end
                    end else if (scl_fal) begin
                        if (bit_reg != 3'h0)
                            bit_reg <= bit_reg - 3'h1;
                        else if (bst_reg == B_ADDR) begin
                            if (addr_ack) begin
                                ack_reg      <= 1'b1;
                                sda_drv_reg  <= 1'b1;
                                rd_dir_reg   <= sh_reg[0];
                                gcall_reg    <= (sh_reg[7:1] == `HSC_GCALL_ADDR);
                                first_wr_reg <= 1'b1;
                                byte_idx_reg <= 3'h0;
                            end else
                                bst_reg <= B_IDLE;     // nack, wait for stop
                        end else begin
                            // further write bytes ignored but acked, save a general call reset byte
                            ack_reg      <= 1'b1;
                            sda_drv_reg  <= 1'b1;
                            first_wr_reg <= 1'b0;
                        end
                    end
                end
                B_RD: begin
                    if (scl_fal) begin
                        if (bit_reg != 3'h0) begin
                            bit_reg     <= bit_reg - 3'h1;
                            sda_drv_reg <= ~sh_reg[bit_reg - 3'h1];
                        end else begin
                            bst_reg     <= B_MACK;
                            sda_drv_reg <= 1'b0;
                        end
                    end
                end
                B_MACK: begin
                    if (scl_ris) begin
                        if (sda_s)
                            bst_reg <= B_IDLE;         // nack releases the bus
                        else begin
                            byte_idx_reg <= byte_idx_reg + 3'h1;
                            bit_reg      <= 3'h7;
                        end
                    end else if (scl_fal) begin
                        bst_reg     <= B_RD;
                        sda_drv_reg <= ~sh_reg[7];
                    end
                end
                default: bst_reg <= B_IDLE;
            endcase
            // load the outgoing byte from the result frame
            if (bst_reg == B_ADDR && scl_fal && ack_reg && rd_dir_reg)
                sh_reg <= res_reg[47:40];
            else if (bst_reg == B_MACK && scl_ris && !sda_s)
                sh_reg <= (byte_idx_reg == 3'h0) ? res_reg[39:32] :
                          (byte_idx_reg == 3'h1) ? res_reg[31:24] :
                          (byte_idx_reg == 3'h2) ? res_reg[23:16] :
                          (byte_idx_reg == 3'h3) ? res_reg[15:8]  : res_reg[7:0];
        end
    end

    // pin drive: low only, open drain, scl untouched
    assign SDA_OUT = 1'b0;
    assign SDA_OE  = sda_drv_reg;

    // sequencer for measurement, heater and reset
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            seq_reg       <= S_IDLE;
            cnt_reg       <= 28'h0;
            meas_len_reg  <= 28'h0;
            serial_reg    <= 1'b0;
            HEATER_PWR    <= `HSC_PWR_OFF;
            BUSY          <= 1'b0;
            res_reg       <= 48'h0;
            res_valid_reg <= 1'b0;
        end else if (srst_cmd) begin
            seq_reg       <= S_SRST;
            cnt_reg       <= CYC_SRST;
            HEATER_PWR    <= `HSC_PWR_OFF;
            BUSY          <= 1'b1;
            res_valid_reg <= 1'b0;
        end else if (cmd_byte && cmd_known && !busy_now) begin
            serial_reg    <= (sh_reg == `HSC_CMD_SERIAL);
            res_valid_reg <= 1'b0;
            BUSY          <= 1'b1;
            meas_len_reg  <= cmd_mlen;
            if (cmd_heat) begin
                seq_reg    <= S_HEAT;
                HEATER_PWR <= cmd_pwr;
                cnt_reg    <= cmd_long ? CYC_LONG : CYC_SHORT;
            end else begin
                seq_reg <= S_MEAS;
                cnt_reg <= cmd_mlen;
            end
        end else if (cmd_byte && !cmd_known && !busy_now) begin
            seq_reg       <= S_IDLE;
            res_valid_reg <= 1'b0;
        end else begin
            case (seq_reg)
                S_IDLE: BUSY <= 1'b0;
                S_HEAT: begin
                    if (cnt_reg == 28'h0) begin
                        seq_reg <= S_MEAS;
                        cnt_reg <= meas_len_reg;
                    end else
                        cnt_reg <= cnt_reg - 28'h1;
                end
                S_MEAS: begin
                    if (cnt_reg == 28'h0) begin
                        seq_reg       <= S_RDY;
                        HEATER_PWR    <= `HSC_PWR_OFF;
                        BUSY          <= 1'b0;
                        res_valid_reg <= 1'b1;
                        if (serial_reg)
                            res_reg <= {SERIAL_NUM[31:16], hsc_crc16(SERIAL_NUM[31:16]),
                                        SERIAL_NUM[15:0], hsc_crc16(SERIAL_NUM[15:0])};
                        else
                            res_reg <= {TEMP_SAMPLE, hsc_crc16(TEMP_SAMPLE),
                                        HUM_SAMPLE, hsc_crc16(HUM_SAMPLE)};
                    end else
                        cnt_reg <= cnt_reg - 28'h1;
                end
                S_SRST: begin
                    if (cnt_reg == 28'h0) begin
                        seq_reg <= S_IDLE;
                        BUSY    <= 1'b0;
                    end else
                        cnt_reg <= cnt_reg - 28'h1;
                end
                S_RDY: begin
                    if (rd_take) begin
                        seq_reg       <= S_IDLE;
                        res_valid_reg <= 1'b0;
                    end
                end
                default: seq_reg <= S_IDLE;
            endcase
        end
    end

endmodule // hsc_top

// file: verif/hsc_props_properties.sv
// checker for hsc_top: sda pin timing, heater and busy bounds
// assumes it is bound into hsc_top and sees only its ports
`timescale 1ns/1ps
module hsc_props #(
    parameter [27:0] CYC_LONG = 28'h10,
    parameter [27:0] CYC_M_HI = 28'h10
) (
    // clock and reset
    input wire       CLK,
    input wire       RST_N,
    // i2c pins
    input wire       SCL_IN,
    input wire       SDA_OUT,
    input wire       SDA_OE,
    // status
    input wire [1:0] HEATER_PWR,
    input wire       BUSY
);
    localparam int HEAT_MAX = CYC_LONG + CYC_M_HI + 8;
    localparam int BUSY_MAX = CYC_LONG + CYC_M_HI + 16;
    default clocking dc @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // unbroken on-time of heater and busy
    reg [31:0] heat_cnt_reg;
    reg [31:0] busy_cnt_reg;
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            heat_cnt_reg <= 32'h0;
            busy_cnt_reg <= 32'h0;
        end else begin
            heat_cnt_reg <= (HEATER_PWR != 2'h0) ? heat_cnt_reg + 32'h1 : 32'h0;
            busy_cnt_reg <= BUSY ? busy_cnt_reg + 32'h1 : 32'h0;
        end
    end
    chk_sda_pull_only: assert property (SDA_OUT == 1'b0)
        else $error("sda driven high");
    chk_oe_quiet_high: assert property (SCL_IN [*6] |-> $stable(SDA_OE))
        else $error("sda moved while scl high");
    chk_oe_rise_low: assert property ($rose(SDA_OE) |-> !SCL_IN)
        else $error("sda pulled while scl high");
    chk_oe_fall_low: assert property ($fell(SDA_OE) |-> !SCL_IN)
        else $error("sda released while scl high");
    chk_heat_in_busy: assert property ((HEATER_PWR != 2'h0) [*3] |-> BUSY)
        else $error("heater on while idle");
    chk_heat_off_ready: assert property ($fell(BUSY) |-> HEATER_PWR == 2'h0)
        else $error("heater on at result ready");
    chk_heat_level_held: assert property ((HEATER_PWR != 2'h0) ##1 (HEATER_PWR != 2'h0)
        |-> HEATER_PWR == $past(HEATER_PWR))
        else $error("heater level changed");
    chk_heat_time_bound: assert property (heat_cnt_reg <= HEAT_MAX)
        else $error("heater on too long");
    chk_busy_time_bound: assert property (busy_cnt_reg <= BUSY_MAX)
        else $error("busy too long");
    cov_heat_high: cover property (HEATER_PWR == 2'h3);
    cov_busy_end: cover property ($fell(BUSY));
    cov_ack: cover property ($rose(SDA_OE));
endmodule // hsc_props
bind hsc_top hsc_props #(.CYC_LONG(CYC_LONG), .CYC_M_HI(CYC_M_HI)) u_props (
    .CLK(CLK), .RST_N(RST_N), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE), .HEATER_PWR(HEATER_PWR), .BUSY(BUSY));

// file: verif/hsc_i2c_master.sv
// i2c controller model: frames transfers, drives scl, pulls sda low
// assumes the bench forms the pulled-up sda level; scl 160 ns
`timescale 1ns/1ps
module hsc_i2c_master (
    // clock
    input  wire clk,
    // bus
    output reg  scl,
    output reg  sda_low,
    input  wire sda
);
    // idle: scl high and still, sda released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task wt(input integer n);
        repeat (n) @(posedge clk);
    endtask
    // one bit: data moves while scl low, sampled mid-high
    task bit_io(input b, output r);
        begin
            wt(4);
            sda_low <= ~b;
            wt(4);
            scl <= 1'b1;
            wt(3);
            @(negedge clk) r = sda;
            wt(5);
            scl <= 1'b0;
        end
    endtask
    // byte out, msb first, then target ack
    task put(input [7:0] d, output ack);
        integer i;
        reg r;
        begin
            for (i = 7; i >= 0; i = i - 1)
                bit_io(d[i], r);
            bit_io(1'b1, r);
            ack = ~r;
        end
    endtask
    // byte in; last byte answered with nack
    task get(input last, output [7:0] d);
        integer i;
        reg r;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                bit_io(1'b1, r);
                d[i] = r;
            end
            bit_io(last, r);
        end
    endtask
    // start, then address and direction bit
    task header(input [6:0] ad, input rd, output ack);
        begin
            wt(8);
            sda_low <= 1'b1;
            wt(8);
            scl <= 1'b0;
            put({ad, rd}, ack);
        end
    endtask
    // stop condition
    task stop;
        begin
            wt(4);
            sda_low <= 1'b1;
            wt(4);
            scl <= 1'b1;
            wt(8);
            sda_low <= 1'b0;
            wt(8);
        end
    endtask
endmodule // hsc_i2c_master

// file: verif/testbench.sv
// self-checking bench for hsc_top: commands, readout, heater, resets
// assumes the i2c controller model and the bound checker
`timescale 1ns/1ps
module testbench;
    localparam [6:0]  DEV  = 7'h44;
    localparam [31:0] SN   = 32'h5a3c_96e1; // arbitrary value
    localparam [23:0] MTAB = 24'hfdf6e0;
    localparam [47:0] HTAB = 48'h392f1e322415;
    localparam integer LONG = 800, SHORT = 300, M_HI = 400, M_MD = 300, M_LO = 200;
    reg         clk, rst_n, a;
    reg  [15:0] temp_s, hum_s, t_e, h_e;
    reg  [31:0] seed;
    reg  [7:0]  b;
    wire        scl, sda_low, sda_out, sda_oe, busy;
    wire [1:0]  heater_pwr;
    // pulled-up line, low when either side pulls
    wire        sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;
    integer     errors, n_compared, busy_b, heat_b, k, i, n;
    integer     busy_cyc = 0;
    integer     heat_cyc = 0;
    integer     bc [0:2];
    hsc_top #(.SERIAL_NUM(SN), .CYC_LONG(LONG), .CYC_SHORT(SHORT), .CYC_M_HI(M_HI),
        .CYC_M_MD(M_MD), .CYC_M_LO(M_LO), .CYC_SRST(10)) u_dut (
        .CLK(clk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe), .TEMP_SAMPLE(temp_s), .HUM_SAMPLE(hum_s),
        .HEATER_PWR(heater_pwr), .BUSY(busy));
    hsc_i2c_master u_m (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // on-time counters
    always @(posedge clk) begin
        if (busy === 1'b1) busy_cyc <= busy_cyc + 1;
        if (heater_pwr !== 2'h0) heat_cyc <= heat_cyc + 1;
    end
    function [31:0] xs(input [31:0] s);
        reg [31:0] x;
        begin
            x = s ^ (s << 13);
            x = x ^ (x >> 17);
            xs = x ^ (x << 5);
        end
    endfunction
    // crc-8, poly 31, init ff, msb first
    function [7:0] crc8(input [15:0] w);
        integer j;
        reg [7:0] c;
        begin
            c = 8'hff;
            for (j = 15; j >= 0; j = j - 1)
                c = (c[7] ^ w[j]) ? {c[6:0], 1'b0} ^ 8'h31 : {c[6:0], 1'b0};
            crc8 = c;
        end
    endfunction
    function [47:0] frame(input [15:0] w1, input [15:0] w2);
        frame = {w1, crc8(w1), w2, crc8(w2)};
    endfunction
    task chk(input [95:0] nm, input [47:0] e, input [47:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task close_out;
        begin
            $display("compared %0d mismatches %0d", n_compared, errors);
            if (errors == 0 && n_compared > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task send_cmd(input [6:0] ad, input [7:0] c);
        begin
            @(negedge clk);
            busy_b = busy_cyc;
            heat_b = heat_cyc;
            u_m.header(ad, 1'b0, a);
            chk("hdr ack", 1, a);
            u_m.put(c, a);
            chk("cmd ack", 1, a);
            u_m.stop;
        end
    endtask
    task read_nack;
        begin
            u_m.header(DEV, 1'b1, a);
            chk("rd hdr nack", 0, a);
            u_m.stop;
        end
    endtask
    task read_frame(input integer nb, input [47:0] f);
        begin
            u_m.header(DEV, 1'b1, a);
            chk("rd hdr ack", 1, a);
            for (i = 0; i < nb; i = i + 1) begin
                u_m.get(i == nb - 1, b);
                chk("rd byte", f[47 - 8 * i -: 8], b);
            end
            u_m.stop;
        end
    endtask
    task wait_idle;
        begin
            for (i = 0; i < 5000 && busy !== 1'b0; i = i + 1)
                @(posedge clk);
            if (busy !== 1'b0) begin
                errors = errors + 1;
                $display("CHECK FAILED busy exp 0 got %b", busy);
                close_out;
            end
            @(negedge clk);
        end
    endtask
    task set_samples(input corner);
        begin
            seed = xs(seed);
            t_e = corner ? 16'hbeef : seed[15:0];
            h_e = corner ? 16'hffff : seed[31:16];
            @(posedge clk);
            temp_s <= t_e;
            hum_s <= h_e;
        end
    endtask
    initial begin
        rst_n = 1'b0;
        temp_s = 16'h0;
        hum_s = 16'h0;
        {errors, n_compared} = 64'h0;
        seed = 32'd29072;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // foreign address, unknown command
        u_m.header(DEV ^ 7'h01, 1'b0, a);
        chk("foreign adr", 0, a);
        u_m.stop;
        send_cmd(DEV, 8'h55);
        read_nack;
        $display("test addressing done");
        // each repeatability level
        for (k = 0; k < 3; k = k + 1) begin
            set_samples(k == 0);
            n = (k == 0) ? M_HI : (k == 1) ? M_MD : M_LO;
            send_cmd(DEV, MTAB[23 - 8 * k -: 8]);
            read_nack;
            wait_idle;
            bc[k] = busy_cyc - busy_b;
            chk("busy window", 1, bc[k] >= n && bc[k] <= n + 6);
            read_frame(6, frame(t_e, h_e));
            read_nack;
        end
        chk("busy order", 1, bc[0] > bc[1] && bc[1] > bc[2]);
        send_cmd(DEV, 8'h89);
        wait_idle;
        read_frame(6, frame(SN[31:16], SN[15:0]));
        $display("test measure and serial done");
        // heater pulses, long then short
        for (k = 0; k < 6; k = k + 1) begin
            set_samples(1'b0);
            send_cmd(DEV, HTAB[47 - 8 * k -: 8]);
            chk("heater pwr", 3 - k % 3, heater_pwr);
            n = ((k < 3) ? LONG : SHORT) + M_HI;
            wait_idle;
            chk("heat window", 1, heat_cyc - heat_b >= n - 2 && heat_cyc - heat_b <= n + 6);
            read_frame(6, frame(t_e, h_e));
            repeat (9 * (heat_cyc - heat_b)) @(posedge clk);
        end
        $display("test heater done");
        // read cut short after the first word
        set_samples(1'b0);
        send_cmd(DEV, 8'hfd);
        wait_idle;
        read_frame(2, frame(t_e, h_e));
        chk("sda release", 0, sda_oe);
        read_nack;
        // soft and general call reset abort heating
        send_cmd(DEV, 8'h39);
        send_cmd(DEV, 8'h94);
        chk("heater off", 0, heater_pwr);
        wait_idle;
        read_nack;
        send_cmd(DEV, 8'h2f);
        send_cmd(7'h00, 8'h06);
        chk("heater off", 0, heater_pwr);
        wait_idle;
        read_nack;
        // hard reset in mid pulse
        send_cmd(DEV, 8'h1e);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk("hard reset", 0, {busy, heater_pwr});
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        read_nack;
        $display("test resets done");
        close_out;
    end
endmodule // testbench
